// *** shared/status_change_pkg.sv ***
package status_change_pkg;
   localparam int unsigned STAT_WIDTH     = 16;
   localparam int unsigned DEC_DIGITS     = 5;
   localparam int unsigned BIT_STABLE     = 12;
   localparam int unsigned BIT_CURR_AMP   = 3;
   localparam int unsigned BIT_VOLT_AMP   = 2;
   localparam logic [15:0] RISE_RESET     = 16'h0000;
   localparam logic [15:0] FALL_RESET     = 16'h0000;
   localparam logic [15:0] RISE_EN_RESET  = 16'hFFFF;
   localparam logic [15:0] FALL_EN_RESET  = 16'hFFFF;
   localparam logic [15:0] REPORT_MAX     = 16'h7FFF;
   localparam int unsigned CONV_CYCLES    = 16;

   typedef enum logic [2:0] {
      CMD_COMBINED   = 3'h0,
      CMD_RISE_QUERY = 3'h1,
      CMD_FALL_QUERY = 3'h2,
      CMD_RISE_EN_LD = 3'h3,
      CMD_FALL_EN_LD = 3'h4
   } cmd_t;

   typedef enum logic [1:0] {
      PORT_GPIB  = 2'h0,
      PORT_RS232 = 2'h1
   } port_t;
endpackage

// *** shared/dec_conv_if.sv ***
`timescale 1ns/1ps
interface dec_conv_if;
   logic        start;
   logic [15:0] value;
   logic        busy;
   logic        done;
   logic [19:0] bcd;
   modport requester (output start, output value, input busy, input done, input bcd);
   modport converter (input start, input value, output busy, output done, output bcd);
endinterface

// *** hdl/dec_convert.sv ***
`timescale 1ns/1ps
// Shift-and-add binary to five BCD digits, one bit per cycle
module dec_convert (
   input wire logic     clk,
   input wire logic     rst,
   input wire logic     ce,
   dec_conv_if.converter cv
);
   logic [15:0] shift_reg;
   logic [19:0] bcd_reg;
   logic [4:0]  count_reg;
   logic        busy_reg;
   logic        done_reg;
   logic [19:0] adj;

   function automatic logic [19:0] add3(input logic [19:0] d);
      logic [19:0] r;
      r = d;
      for (int i = 0; i < 5; i++) begin
         if (d[i*4 +: 4] > 4'h4) begin
            r[i*4 +: 4] = d[i*4 +: 4] + 4'h3;
         end
      end
      return r;
   endfunction

   assign adj     = add3(bcd_reg);
   assign cv.busy = busy_reg;
   assign cv.done = done_reg;
   assign cv.bcd  = bcd_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shift_reg <= 16'h0000;
         bcd_reg   <= 20'h00000;
         count_reg <= 5'h00;
         busy_reg  <= 1'b0;
         done_reg  <= 1'b0;
      end else if (ce) begin
         done_reg <= 1'b0;
         if (cv.start && !busy_reg) begin
            shift_reg <= cv.value;
            bcd_reg   <= 20'h00000;
            count_reg <= 5'(status_change_pkg::CONV_CYCLES);
            busy_reg  <= 1'b1;
         end else if (busy_reg) begin
            bcd_reg   <= {adj[18:0], shift_reg[15]};
            shift_reg <= {shift_reg[14:0], 1'b0};
            count_reg <= count_reg - 5'h01;
            if (count_reg == 5'h01) begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
         end
      end
   end
endmodule

// *** hdl/status_change_readclear.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - The combined query clears both change registers when it is taken, leaving only that cycle's new events, then reports both values, rising first.
// - The rising-change query returns that register and clears it as part of the read.
// - The falling-change query returns that register and clears it as part of the read.
// - Every answer is the decimal value of the low fifteen bits of the contents, from 0 to 32767.
// - Bit 12 follows output stable, bit 3 current amplifier, bit 2 voltage amplifier.
// - Queries are taken from either remote port and run strictly one after another.
module status_change_readclear (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [15:0] status_in,
   input  wire logic        output_stable_flag,
   input  wire logic        current_amp_active_flag,
   input  wire logic        voltage_amp_active_flag,
   input  wire logic        cmd_valid,
   input  wire logic [2:0]  cmd_code,
   input  wire logic [1:0]  cmd_port,
   input  wire logic [7:0]  cmd_hi_byte,
   input  wire logic [7:0]  cmd_lo_byte,
   output wire logic        cmd_ready,
   output logic             resp_valid,
   output logic [19:0]      resp_digits,
   output logic [1:0]       resp_port,
   output logic             resp_last,
   output logic [15:0]      status_rise_change,
   output logic [15:0]      status_fall_change,
   output logic [15:0]      fall_change_enable_mask
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_CONV = 2'h1,
      ST_NEXT = 2'h2
   } state_t;

   state_t      state_reg;
   logic [15:0] sync1_reg;
   logic [15:0] sync2_reg;
   logic [15:0] sync3_reg;
   logic [15:0] stable_reg;
   logic [15:0] prev_reg;
   logic [15:0] rise_en_reg;
   logic [15:0] fall_snap_reg;
   logic        second_reg;
   logic [1:0]  port_reg;
   logic        conv_start_reg;
   logic [15:0] conv_value_reg;
   // Arms edge detection only once the three stages and the compare hold the real pin level,
   // so the zeros left by reset never show up as changes
   logic [3:0]  arm_reg;

   dec_conv_if cv ();

   dec_convert u_conv (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .cv  (cv)
   );

   // Status word with the named flags placed at their fixed positions
   wire logic [15:0] status_word;
   assign status_word = {status_in[15:13], output_stable_flag, status_in[11:4],
                         current_amp_active_flag, voltage_amp_active_flag, status_in[1:0]};

   // A change counts once the second and third stages agree
   wire logic [15:0] agreed;
   // Where the stages disagree the last agreed level is kept
   assign agreed = (sync2_reg & sync3_reg) | (stable_reg & (sync2_reg ^ sync3_reg));

   wire logic [15:0] rise_events;
   wire logic [15:0] fall_events;
   assign rise_events = arm_reg[3] ? (agreed & ~prev_reg & rise_en_reg) : 16'h0000;
   assign fall_events = arm_reg[3] ? (~agreed & prev_reg & fall_change_enable_mask) : 16'h0000;

   wire logic   accept;
   wire status_change_pkg::cmd_t code;
   assign cmd_ready = (state_reg == ST_IDLE);
   assign accept    = ce && cmd_valid && cmd_ready;
   assign code      = status_change_pkg::cmd_t'(cmd_code);

   wire logic clr_rise;
   wire logic clr_fall;
   assign clr_rise = accept && (code == status_change_pkg::CMD_COMBINED ||
                                code == status_change_pkg::CMD_RISE_QUERY);
   assign clr_fall = accept && (code == status_change_pkg::CMD_COMBINED ||
                                code == status_change_pkg::CMD_FALL_QUERY);
   wire logic is_query;
   assign is_query = clr_rise || clr_fall;

   wire logic [15:0] rise_next;
   wire logic [15:0] fall_next;
   // New events that land in the read cycle are kept, so none is lost
   assign rise_next = (clr_rise ? 16'h0000 : status_rise_change) | rise_events;
   assign fall_next = (clr_fall ? 16'h0000 : status_fall_change) | fall_events;

   wire logic [15:0] query_value;
   assign query_value = (code == status_change_pkg::CMD_FALL_QUERY) ? status_fall_change
                                                                    : status_rise_change;

   assign cv.start = conv_start_reg;
   assign cv.value = conv_value_reg & status_change_pkg::REPORT_MAX;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg  <= 16'h0000;
         sync2_reg  <= 16'h0000;
         sync3_reg  <= 16'h0000;
         stable_reg <= 16'h0000;
         prev_reg   <= 16'h0000;
         arm_reg    <= 4'h0;
      end else if (ce) begin
         sync1_reg  <= status_word;
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         stable_reg <= agreed;
         prev_reg   <= agreed;
         arm_reg    <= {arm_reg[2:0], 1'b1};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_rise_change      <= status_change_pkg::RISE_RESET;
         status_fall_change      <= status_change_pkg::FALL_RESET;
         rise_en_reg             <= status_change_pkg::RISE_EN_RESET;
         fall_change_enable_mask <= status_change_pkg::FALL_EN_RESET;
      end else if (ce) begin
         status_rise_change <= rise_next;
         status_fall_change <= fall_next;
         if (accept && code == status_change_pkg::CMD_FALL_EN_LD) begin
            fall_change_enable_mask <= {cmd_hi_byte, cmd_lo_byte};
         end
         if (accept && code == status_change_pkg::CMD_RISE_EN_LD) begin
            rise_en_reg <= {cmd_hi_byte, cmd_lo_byte};
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg      <= ST_IDLE;
         second_reg     <= 1'b0;
         port_reg       <= 2'h0;
         conv_start_reg <= 1'b0;
         conv_value_reg <= 16'h0000;
         fall_snap_reg  <= 16'h0000;
         resp_valid     <= 1'b0;
         resp_digits    <= 20'h00000;
         resp_port      <= 2'h0;
         resp_last      <= 1'b0;
      end else if (ce) begin
         conv_start_reg <= 1'b0;
         resp_valid     <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (is_query) begin
                  port_reg       <= cmd_port;
                  conv_value_reg <= query_value;
                  fall_snap_reg  <= status_fall_change;
                  second_reg     <= (code == status_change_pkg::CMD_COMBINED);
                  conv_start_reg <= 1'b1;
                  state_reg      <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (cv.done) begin
                  resp_valid  <= 1'b1;
                  resp_digits <= cv.bcd;
                  resp_port   <= port_reg;
                  resp_last   <= !second_reg;
                  state_reg   <= second_reg ? ST_NEXT : ST_IDLE;
               end
            end
            ST_NEXT: begin
               second_reg     <= 1'b0;
               conv_value_reg <= fall_snap_reg;
               conv_start_reg <= 1'b1;
               state_reg      <= ST_CONV;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   a_rise_clear: assert property (@(posedge clk) disable iff (rst)
      (ce && clr_rise) |=> (status_rise_change == $past(rise_events)))
      else $error("rising register not cleared by query");

   a_fall_clear: assert property (@(posedge clk) disable iff (rst)
      (ce && clr_fall) |=> (status_fall_change == $past(fall_events)))
      else $error("falling register not cleared by query");

   a_combined_two: assert property (@(posedge clk) disable iff (rst)
      (accept && code == status_change_pkg::CMD_COMBINED && ce) |-> ##19 (resp_valid && !resp_last))
      else $error("combined query missing first answer");

   a_change_hold: assert property (@(posedge clk) disable iff (rst)
      (ce && !clr_rise && |status_rise_change) |=> ((status_rise_change & $past(status_rise_change))
                                                   == $past(status_rise_change)))
      else $error("rising change bit lost without read");

   a_report_range: assert property (@(posedge clk) disable iff (rst)
      resp_valid |-> (resp_digits[19:16] <= 4'h3))
      else $error("reported value above range");

   a_one_at_time: assert property (@(posedge clk) disable iff (rst)
      (ce && is_query) |-> ##19 (resp_valid && resp_port == $past(cmd_port, 19)))
      else $error("query answer missing or on wrong port");

   a_mask_load: assert property (@(posedge clk) disable iff (rst)
      (accept && code == status_change_pkg::CMD_FALL_EN_LD) |=>
         (fall_change_enable_mask == $past({cmd_hi_byte, cmd_lo_byte})))
      else $error("falling enable mask not loaded");

   a_masked_fall: assert property (@(posedge clk) disable iff (rst)
      (ce && !clr_fall) |=> ((status_fall_change & ~$past(status_fall_change) &
                              ~$past(fall_change_enable_mask)) == 16'h0000))
      else $error("disabled falling bit was set");
endmodule

// *** tb/host_model.sv ***
`timescale 1ns/1ps
// Remote host: one command at a time, each answer awaited before the next
module host_model (
   input  wire logic        clk,
   input  wire logic        cmd_ready,
   input  wire logic        resp_valid,
   input  wire logic [19:0] resp_digits,
   input  wire logic [1:0]  resp_port,
   input  wire logic        resp_last,
   output logic             cmd_valid,
   output logic [2:0]       cmd_code,
   output logic [1:0]       cmd_port,
   output logic [7:0]       cmd_hi_byte,
   output logic [7:0]       cmd_lo_byte
);
   initial begin
      {cmd_valid, cmd_code, cmd_port, cmd_hi_byte, cmd_lo_byte} = '0;
   end

   // Request held until taken; released bytes then show their inverse
   task automatic send(input logic [2:0] c, input logic [1:0] p, input logic [15:0] m, input int slow,
                       output bit ok);
      repeat (slow + 1) @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_port <= p;
      {cmd_hi_byte, cmd_lo_byte} <= m;
      ok = 1'b0;
      for (int n = 0; n < 64 && !ok; n++) begin
         @(posedge clk);
         ok = cmd_ready;
      end
      cmd_valid <= 1'b0;
      {cmd_hi_byte, cmd_lo_byte} <= ~m;
   endtask

   task automatic get(output logic [19:0] d, output logic [1:0] p, output logic l, output bit ok);
      ok = 1'b0;
      for (int n = 0; n < 64 && !ok; n++) begin
         @(posedge clk);
         ok = resp_valid;
      end
      d = resp_digits;
      p = resp_port;
      l = resp_last;
   endtask
endmodule

// *** tb/status_change_readclear_tb.sv ***
`timescale 1ns/1ps
module status_change_readclear_tb;
   logic        clk, rst, ce, cmd_valid, cmd_ready, resp_valid, resp_last, fl_st, fl_ca, fl_va;
   logic [15:0] status_in, rise_q, fall_q, fmask_q, cur, m_rise, m_fall, m_ren, m_fen, fz_rise, fz_fall;
   logic [19:0] resp_digits;
   logic [2:0]  cmd_code;
   logic [1:0]  cmd_port, resp_port;
   logic [7:0]  cmd_hi_byte, cmd_lo_byte;
   bit          ok;
   int          num_errors = 0;
   int          checked = 0;

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   status_change_readclear status_change_readclear_inst (.clk(clk), .rst(rst), .ce(ce),
      .status_in(status_in), .output_stable_flag(fl_st), .current_amp_active_flag(fl_ca),
      .voltage_amp_active_flag(fl_va), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_port(cmd_port),
      .cmd_hi_byte(cmd_hi_byte), .cmd_lo_byte(cmd_lo_byte), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
      .resp_digits(resp_digits), .resp_port(resp_port), .resp_last(resp_last), .status_rise_change(rise_q),
      .status_fall_change(fall_q), .fall_change_enable_mask(fmask_q));

   host_model host_model_inst (.clk(clk), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
      .resp_digits(resp_digits), .resp_port(resp_port), .resp_last(resp_last), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_port(cmd_port), .cmd_hi_byte(cmd_hi_byte), .cmd_lo_byte(cmd_lo_byte));

   function automatic logic [19:0] to_dec(input logic [15:0] v);
      int x;
      x = int'(v & 16'h7FFF);
      return {4'(x / 10000), 4'(x / 1000 % 10), 4'(x / 100 % 10), 4'(x / 10 % 10), 4'(x % 10)};
   endfunction

   task automatic chk_resp(input logic [19:0] got, input logic [19:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t answer %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t register %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic fail_if(input bit good);
      if (!good) begin
         num_errors++;
         $display("[ERR] %0t handshake did not complete", $time);
         report_and_stop();
      end
   endtask

   // Raw bits 12, 3 and 2 are inverted so only the flag pins can supply them
   task automatic set_status(input logic [15:0] s);
      @(posedge clk);
      status_in <= s ^ 16'h100C;
      {fl_st, fl_ca, fl_va} <= {s[12], s[3], s[2]};
      m_rise = m_rise | (~cur & s & m_ren);
      m_fall = m_fall | (cur & ~s & m_fen);
      cur = s;
      repeat (8) @(posedge clk);
   endtask

   task automatic query(input logic [2:0] c, input logic [1:0] p);
      logic [19:0] d;
      logic [1:0]  rp;
      logic        l;
      logic [15:0] r, f;
      r = m_rise;
      f = m_fall;
      host_model_inst.send(c, p, 16'h0000, $urandom_range(3), ok);
      fail_if(ok);
      if (c != 3'h2) begin
         m_rise = 16'h0000;
         host_model_inst.get(d, rp, l, ok);
         fail_if(ok);
         chk_resp(d, to_dec(r));
         chk_resp({17'h0, l, rp}, {17'h0, c == 3'h1, p});
      end
      if (c != 3'h1) begin
         m_fall = 16'h0000;
         host_model_inst.get(d, rp, l, ok);
         fail_if(ok);
         chk_resp(d, to_dec(f));
         chk_resp({17'h0, l, rp}, {17'h0, 1'b1, p});
      end
      chk_reg(rise_q, m_rise);
      chk_reg(fall_q, m_fall);
   endtask

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      status_in = 16'h100C;
      {fl_st, fl_ca, fl_va} = 3'b000;
      {cur, m_rise, m_fall} = '0;
      void'($urandom(86));
      m_ren = 16'hFFFF;
      m_fen = 16'hFFFF;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk_reg(rise_q, 16'h0000);
      chk_reg(fall_q, 16'h0000);
      chk_reg(fmask_q, 16'hFFFF);
      m_fen = 16'($urandom) | 16'h1004;
      host_model_inst.send(3'h4, 2'h1, m_fen, 0, ok);
      fail_if(ok);
      m_ren = 16'($urandom) | 16'h1008;
      host_model_inst.send(3'h3, 2'h0, m_ren, 0, ok);
      fail_if(ok);
      @(posedge clk);
      chk_reg(fmask_q, m_fen);
      host_model_inst.send(3'h5, 2'h0, 16'h0000, 0, ok);
      fail_if(ok);
      for (int i = 0; i < 15; i++) begin
         // A pin change while frozen must leave both change registers alone until enable returns
         if (i == 7) begin
            fz_rise = m_rise;
            fz_fall = m_fall;
            ce <= 1'b0;
            set_status(16'($urandom));
            chk_reg(rise_q, fz_rise);
            chk_reg(fall_q, fz_fall);
            ce <= 1'b1;
            repeat (8) @(posedge clk);
         end
         set_status(16'($urandom));
         set_status(16'($urandom));
         query(3'(i % 3), 2'($urandom_range(1)));
      end
      query(3'h0, 2'h1);
      report_and_stop();
   end
endmodule
